/* test/tb_three_level_vectored_interrupt_unit.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_three_level_vectored_interrupt_unit
   import tlviu_pkg::*;
;
   logic        clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, ext_irq_b, ext_irq_c, ext_irq_d, wake, irq;
   logic        cpu_boundary, cpu_reti, cpu_halt, cpu_hold, program_bank_flag, ram_we, sp_load, pc_load;
   logic        slow, ret_req;
   logic [3:0]  wb_sel;
   logic [7:0]  wb_adr;
   logic [31:0] wb_dat_w, wb_dat_r, q;
   logic [20:0] src_req;
   logic [16:0] cpu_pc, pc_val;
   logic [15:0] cpu_sp, ram_addr, sp_val;
   logic [8:0]  ram_wdata;
   int          n_mismatch, num_checks, cycles, n_wake;
   int          vmap [0:20] = '{0, 0, 1, 1, 2, 2, 2, 3, 3, 4, 5, 5, 6, 7, 7, 8, 8, 8, 8, 9, 9};
   tlviu_ctrl tlviu_ctrl_i (.clk(clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
      .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
      .src_req(src_req), .ext_irq_b(ext_irq_b), .ext_irq_c(ext_irq_c), .ext_irq_d(ext_irq_d),
      .cpu_boundary(cpu_boundary), .cpu_reti(cpu_reti), .cpu_halt(cpu_halt), .cpu_hold(cpu_hold),
      .cpu_pc(cpu_pc), .program_bank_flag(program_bank_flag), .cpu_sp(cpu_sp), .ram_we(ram_we),
      .ram_addr(ram_addr), .ram_wdata(ram_wdata), .sp_load(sp_load), .sp_val(sp_val), .pc_load(pc_load),
      .pc_val(pc_val), .wake(wake), .irq(irq));
   tlviu_core_model tlviu_core_model_i (.clk(clk), .rst_n(rst_n), .slow(slow), .ret_req(ret_req),
      .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .sp_load(sp_load), .sp_val(sp_val),
      .pc_load(pc_load), .pc_val(pc_val), .cpu_boundary(cpu_boundary), .cpu_reti(cpu_reti),
      .cpu_pc(cpu_pc), .program_bank_flag(program_bank_flag), .cpu_sp(cpu_sp));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Run takes about 1000 cycles; the ceiling only catches a hang
   always @(posedge clk) begin
      cycles++;
      if (wake === 1'b1) n_wake++;
      if (cycles == 6000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'b11, we, a, d};
      do @(posedge clk); while (wb_ack !== 1'b1);
      q = wb_dat_r;
      {wb_cyc, wb_stb} <= 2'b00;
      @(posedge clk);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask : wr
   task automatic pin(input int p, input logic v, input int n);
      if (p == 1) ext_irq_d <= v;
      else ext_irq_c <= v;
      repeat (n) @(posedge clk);
   endtask : pin
   task automatic sts(input int b, input logic e);
      wb(1'b0, OFS_STATUS, 32'h0);
      `CHK(q[b], e)
      wr(OFS_CLEAR, 32'h1F);
   endtask : sts
   task automatic enter(input logic [16:0] pc_exp);
      logic [16:0] pc0;
      logic [15:0] sp0;
      logic        b0;
      int          n;
      pc0 = cpu_pc;
      b0 = program_bank_flag;
      sp0 = cpu_sp;
      n = 0;
      while (pc_load !== 1'b1 && n < 30) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      `CHK(cpu_pc, pc_exp)
      `CHK(program_bank_flag, 1'b0)
      `CHK(cpu_sp, sp0 + 16'h2)
      `CHK(tlviu_core_model_i.stk[sp0[3:0] + 4'h1], {b0, pc0[7:0]})
      `CHK(tlviu_core_model_i.stk[sp0[3:0] + 4'h2], pc0[16:8])
   endtask : enter
   task automatic ret();
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : ret
   task automatic quiet(input int n);
      int seen;
      seen = 0;
      repeat (n) begin
         @(posedge clk);
         if (pc_load === 1'b1) seen++;
      end
      `CHK(seen, 0)
   endtask : quiet
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask : rd_chk
   initial begin
      {rst_n, wb_cyc, wb_stb, wb_we, ext_irq_b, ext_irq_c, ext_irq_d, cpu_halt, cpu_hold, slow, ret_req} = '0;
      wb_sel = 4'hF;
      wb_adr = 8'h00;
      wb_dat_w = 32'h0;
      src_req = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(cpu_pc, 17'h00000)
      rd_chk(OFS_CFG, 32'h05);
      rd_chk(OFS_LVLSEL, 32'h0);
      rd_chk(OFS_INSVC, 32'h0);
      rd_chk(8'h1C, 32'h0);
      // Each source alone, all at the low level
      for (int s = 0; s < NUM_SRC; s++) begin
         slow <= s[0];
         src_req <= 21'h1 << s;
         @(posedge clk);
         enter(17'(3 + 8 * vmap[s]));
         src_req <= '0;
         ret();
         `CHK(cpu_pc, 17'h00000)
      end
      wr(OFS_LVLSEL, 32'h201);
      src_req <= 21'h081004;
      @(posedge clk);
      enter(17'h0004B);
      quiet(10);
      rd_chk(OFS_PEND, 32'h242);
      src_req <= 21'h081005;
      @(posedge clk);
      enter(17'h00003);
      rd_chk(OFS_INSVC, 32'hB);
      src_req <= 21'h001004;
      ret();
      rd_chk(OFS_INSVC, 32'h6);
      quiet(6);
      ret();
      enter(17'h0000B);
      src_req <= 21'h001000;
      ret();
      enter(17'h00033);
      src_req <= '0;
      ret();
      `CHK(cpu_pc, 17'h00000)
      for (int p = 0; p < 2; p++) begin
         for (int m = 1; m < 4; m++) begin
            wr(OFS_CFG, m << (2 * p));
            pin(p, 1'b1, 6);
            sts(1 + p, m[0]);
            pin(p, 1'b0, 6);
            sts(1 + p, m[1]);
         end
      end
      wr(OFS_CFG, 32'h11);
      pin(0, 1'b1, 20);
      pin(0, 1'b0, 45);
      sts(1, 1'b0);
      pin(0, 1'b1, 45);
      sts(1, 1'b1);
      pin(0, 1'b0, 45);
      wr(OFS_CFG, 32'h21);
      pin(0, 1'b1, 100);
      sts(1, 1'b0);
      pin(0, 1'b1, 45);
      sts(1, 1'b1);
      pin(0, 1'b0, 140);
      wr(OFS_CFG, 32'h05);
      ext_irq_b <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(OFS_STATUS, 32'h1);
      `CHK(irq, 1'b0)
      wr(OFS_ENABLE, 32'h1);
      @(posedge clk);
      `CHK(irq, 1'b1)
      enter(17'h00013);
      wr(OFS_CLEAR, 32'h1);
      @(posedge clk);
      `CHK(irq, 1'b0)
      ext_irq_b <= 1'b0;
      wr(OFS_ENABLE, 32'h0);
      ret();
      cpu_hold <= 1'b1;
      src_req <= 21'h001000;
      n_wake = 0;
      pin(0, 1'b1, 10);
      `CHK(n_wake, 0)
      ext_irq_b <= 1'b1;
      // Space the two pin events so each raises a wake pulse of its own
      repeat (4) @(posedge clk);
      pin(1, 1'b1, 10);
      `CHK(n_wake, 2)
      rd_chk(OFS_STATUS, 32'h1F);
      cpu_hold <= 1'b0;
      cpu_halt <= 1'b1;
      enter(17'h00033);
      `CHK(n_wake >= 3, 1'b1)
      cpu_halt <= 1'b0;
      src_req <= '0;
      ret();
      end_sim();
   end
endmodule : tb_three_level_vectored_interrupt_unit

/* test/tlviu_assertions.sv */
`timescale 1ns/1ns
module tlviu_assertions
   import tlviu_pkg::*;
(
   // Clock, reset and bus
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        wb_cyc,
   input wire logic        wb_stb,
   input wire logic        wb_we,
   input wire logic [7:0]  wb_adr,
   input wire logic [31:0] wb_dat_r,
   input wire logic        wb_ack,
   // Core side
   input wire logic        ext_irq_b,
   input wire logic        cpu_reti,
   input wire logic        cpu_hold,
   input wire logic [16:0] cpu_pc,
   input wire logic        program_bank_flag,
   input wire logic [15:0] cpu_sp,
   input wire logic        ram_we,
   input wire logic [15:0] ram_addr,
   input wire logic [8:0]  ram_wdata,
   input wire logic        sp_load,
   input wire logic [15:0] sp_val,
   input wire logic        pc_load,
   input wire logic [16:0] pc_val,
   input wire logic        wake
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------
   // Entry steps
   // ----------
   sequence push_lo; ram_we && !sp_load; endsequence
   sequence push_hi; ram_we && sp_load; endsequence
   sequence entry; push_lo ##1 push_hi; endsequence
   a_ack_next: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack) else $error("ack late");
   a_ack_pulse: assert property (wb_ack |=> !wb_ack) else $error("ack held");
   a_unmapped_zero: assert property (wb_ack && !wb_we && wb_adr > OFS_PEND |-> wb_dat_r == 32'h0)
      else $error("unmapped read not zero");
   a_push_low: assert property (push_lo |-> ram_addr == cpu_sp + 16'h1 && ram_wdata == {program_bank_flag, cpu_pc[7:0]})
      else $error("first push wrong");
   a_push_high: assert property (push_lo |=> push_hi and (ram_addr == cpu_sp + 16'h2 && ram_wdata == cpu_pc[16:8] && sp_val == cpu_sp + 16'h2))
      else $error("second push wrong");
   a_vec_load: assert property (entry |=> pc_load && pc_val[2:0] == 3'h3 && pc_val <= 17'h0004B ##1 !pc_load)
      else $error("vector load wrong");
   a_reti_block: assert property (cpu_reti |=> !(ram_we && !sp_load))
      else $error("accept beside return");
   a_wake_pulse: assert property (wake |=> !wake)
      else $error("wake too long");
   a_hold_wake: assert property (cpu_hold && $rose(ext_irq_b) |-> ##[1:3] wake)
      else $error("no wake from pin");
   // Standby keeps the core frozen, so no entry may start there
   a_hold_still: assert property (cpu_hold && !ram_we && !pc_load |=> !ram_we) else $error("entry in standby");
endmodule : tlviu_assertions

bind tlviu_ctrl tlviu_assertions tlviu_assertions_i (
   .clk(clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
   .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .ext_irq_b(ext_irq_b), .cpu_reti(cpu_reti), .cpu_hold(cpu_hold),
   .cpu_pc(cpu_pc), .program_bank_flag(program_bank_flag), .cpu_sp(cpu_sp), .ram_we(ram_we),
   .ram_addr(ram_addr), .ram_wdata(ram_wdata), .sp_load(sp_load), .sp_val(sp_val), .pc_load(pc_load),
   .pc_val(pc_val), .wake(wake));

/* test/tlviu_core_model.sv */
`timescale 1ns/1ns
module tlviu_core_model
   import tlviu_pkg::*;
(
   // Clock, reset and bench control
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        slow,
   input  wire logic        ret_req,
   // Interrupt unit outputs
   input  wire logic        ram_we,
   input  wire logic [15:0] ram_addr,
   input  wire logic [8:0]  ram_wdata,
   input  wire logic        sp_load,
   input  wire logic [15:0] sp_val,
   input  wire logic        pc_load,
   input  wire logic [16:0] pc_val,
   // Core state
   output logic             cpu_boundary,
   output logic             cpu_reti,
   output logic      [16:0] cpu_pc,
   output logic             program_bank_flag,
   output logic      [15:0] cpu_sp
);
   logic [8:0] stk [0:15];
   // Returns pop the pushed words, so a bad push shows as a wrong return address
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_boundary <= 1'b0;
         cpu_reti <= 1'b0;
         cpu_pc <= 17'h1FFFF;
         program_bank_flag <= 1'b1;
         cpu_sp <= 16'h0000;
      end else begin
         cpu_boundary <= slow ? ~cpu_boundary : 1'b1;
         cpu_reti <= ret_req;
         if (ram_we) stk[ram_addr[3:0]] <= ram_wdata;
         if (sp_load) cpu_sp <= sp_val;
         if (pc_load) begin
            cpu_pc <= pc_val;
            program_bank_flag <= 1'b0;
         end
         if (ret_req) begin
            cpu_pc <= {stk[cpu_sp[3:0]], stk[cpu_sp[3:0] - 4'h1][7:0]};
            program_bank_flag <= stk[cpu_sp[3:0] - 4'h1][8];
            cpu_sp <= cpu_sp - 16'h2;
         end
      end
   end
endmodule : tlviu_core_model

/* verilog/tlviu_ctrl.sv */
`timescale 1ns/1ns
// Function
// - Three levels, highest above high above low, order every decision.
// - In service, hold off requests at or below current level.
// - Among pending vectors grant the highest assigned level.
// - Equal levels: lowest vector address wins.
// - Twenty-one sources merge onto ten vectors; handler finds the source.
// - Vectors 00003H and 0000BH carry comparator events, highest or low only.
// - Vectors 00013H to 0004BH take high or low level only.
// - Serial, converter, timer and surge sources share upper vectors.
// - External inputs c and d trigger on rise, fall or both edges.
// - External input c filtered over 1, 32 or 128 instruction cycles.
// - Halted core is released by any acceptable request, or reset.
// - Deep standby released only by external inputs b or d.
// - Entry loads vector into program counter, clears bank; reset loads zero.
// - Push bank and low PC at SP+1, high bits at SP+2, SP+=2.
module tlviu_ctrl
   import tlviu_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Wishbone slave
   input  wire logic        wb_cyc,
   input  wire logic        wb_stb,
   input  wire logic        wb_we,
   input  wire logic [7:0]  wb_adr,
   input  wire logic [3:0]  wb_sel,
   input  wire logic [31:0] wb_dat_w,
   output logic      [31:0] wb_dat_r,
   output logic             wb_ack,
   // Request sources and pins
   input  wire logic [20:0] src_req,
   input  wire logic        ext_irq_b,
   input  wire logic        ext_irq_c,
   input  wire logic        ext_irq_d,
   // Core side
   input  wire logic        cpu_boundary,
   input  wire logic        cpu_reti,
   input  wire logic        cpu_halt,
   input  wire logic        cpu_hold,
   input  wire logic [16:0] cpu_pc,
   input  wire logic        program_bank_flag,
   input  wire logic [15:0] cpu_sp,
   output logic             ram_we,
   output logic      [15:0] ram_addr,
   output logic      [8:0]  ram_wdata,
   output logic             sp_load,
   output logic      [15:0] sp_val,
   output logic             pc_load,
   output logic      [16:0] pc_val,
   output logic             wake,
   output logic             irq
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   tlviu_state_t  state_ff;
   tlviu_state_t  nxt_state;
   tlviu_lvl_t    cur_lvl_ff;
   tlviu_lvl_t    best_lvl;
   tlviu_lvl_t    lvl_stk_ff [0:STK_DEPTH-1];
   tlviu_lvl_t    vlvl [0:NUM_VEC-1];
   logic [1:0]    depth_ff;
   logic [9:0]    lvlsel_ff;
   logic [5:0]    cfg_ff;
   logic [4:0]    sts_ff;
   logic [4:0]    ena_ff;
   logic          ack_ff;
   logic [31:0]   rdat_ff;
   logic          b_prev_ff;
   logic          c_prev_ff;
   logic          d_prev_ff;
   logic          c_flt_ff;
   logic [7:0]    flt_cnt_ff;
   logic [3:0]    vec_ff;
   logic [8:0]    pc_sv_ff;
   logic [15:0]   sp_sv_ff;
   logic          ram_we_ff;
   logic [15:0]   ram_addr_ff;
   logic [8:0]    ram_wdata_ff;
   logic          sp_load_ff;
   logic [15:0]   sp_val_ff;
   logic          pc_load_ff;
   logic [16:0]   pc_val_ff;
   logic          wake_ff;
   logic          irq_ff;
   logic [3:0]    best_idx;
   logic [9:0]    vreq;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   function automatic logic [15:0] lanes(input logic [15:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
      logic [15:0] m;
      m = {{8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (dat[15:0] & m);
   endfunction : lanes

   wire        bus_req   = wb_cyc & wb_stb;
   wire        wr_take   = bus_req & wb_we & ack_ff;
   wire        wr_lvlsel = wr_take & (wb_adr == OFS_LVLSEL);
   wire        wr_cfg    = wr_take & (wb_adr == OFS_CFG);
   wire        wr_clear  = wr_take & (wb_adr == OFS_CLEAR);
   wire        wr_enable = wr_take & (wb_adr == OFS_ENABLE);
   wire [15:0] lvl_wr    = lanes({6'h00, lvlsel_ff}, wb_dat_w, wb_sel);
   wire [15:0] cfg_wr    = lanes({10'h000, cfg_ff}, wb_dat_w, wb_sel);
   wire [15:0] ena_wr    = lanes({11'h000, ena_ff}, wb_dat_w, wb_sel);
   wire [4:0]  clr_bits  = wr_clear & wb_sel[0] ? wb_dat_w[4:0] : 5'h00;
   wire [31:0] rd_val    = (wb_adr == OFS_LVLSEL) ? {22'h000000, lvlsel_ff} :
                           (wb_adr == OFS_CFG)    ? {26'h0000000, cfg_ff} :
                           (wb_adr == OFS_STATUS) ? {27'h0000000, sts_ff} :
                           (wb_adr == OFS_ENABLE) ? {27'h0000000, ena_ff} :
                           (wb_adr == OFS_INSVC)  ? {28'h0000000, depth_ff, cur_lvl_ff} :
                           (wb_adr == OFS_PEND)   ? {22'h000000, vreq} : 32'h00000000;

   // ----------------------------------------
   // Pin qualification
   // ----------------------------------------
   function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
      return (mode[0] & ~prev & cur) | (mode[1] & prev & ~cur);
   endfunction : edge_hit

   wire [1:0] flt_sel  = cfg_ff[CFG_FLT+:2];
   wire [7:0] flt_len  = (flt_sel == 2'h0) ? FLT_SHORT_CLKS :
                         (flt_sel == 2'h1) ? FLT_MID_CLKS : FLT_LONG_CLKS;
   // A level must differ from the filtered value for the whole window to pass
   wire       c_moved  = ext_irq_c ^ c_flt_ff;
   wire       flt_done = c_moved & ((flt_cnt_ff + 8'h01) >= flt_len);
   wire [7:0] nxt_flt_cnt = (!c_moved || flt_done) ? 8'h00 : flt_cnt_ff + 8'h01;
   wire       nxt_c_flt   = flt_done ? ext_irq_c : c_flt_ff;
   wire       ev_b = ~b_prev_ff & ext_irq_b;
   wire       ev_c = edge_hit(cfg_ff[CFG_C_EDGE+:2], c_prev_ff, c_flt_ff);
   wire       ev_d = edge_hit(cfg_ff[CFG_D_EDGE+:2], d_prev_ff, ext_irq_d);

   // ----------------------------------------
   // Source merge and levels
   // ----------------------------------------
   wire [4:0]  sts_live = sts_ff & ena_ff;
   wire [20:0] ext_req  = (21'(sts_live[STS_EXT_B]) << SRC_EXT_B) |
                          (21'(sts_live[STS_EXT_C]) << SRC_EXT_C) |
                          (21'(sts_live[STS_EXT_D]) << SRC_EXT_D);
   wire [20:0] req_all  = src_req | ext_req;

   genvar v;
   generate
      for (v = 0; v < NUM_VEC; v++) begin : g_vec
         assign vreq[v] = |(req_all & VEC_MASK[v]);
         // Upper choice is highest for the first two vectors, high for the rest
         assign vlvl[v] = !vreq[v] ? LVL_NONE :
                          !lvlsel_ff[v] ? LVL_L :
                          (v < NUM_XVEC) ? LVL_X : LVL_H;
      end
   endgenerate

   // Scan from the top so a lower vector of equal level replaces a higher one
   always_comb begin
      best_lvl = LVL_NONE;
      best_idx = 4'h0;
      for (int i = NUM_VEC - 1; i >= 0; i--) begin
         if (vlvl[i] != LVL_NONE && vlvl[i] >= best_lvl) begin
            best_lvl = vlvl[i];
            best_idx = 4'(i);
         end
      end
   end

   wire above    = best_lvl > cur_lvl_ff;
   wire pop      = cpu_reti & (depth_ff != 2'h0);
   wire accept   = above & (state_ff == S_IDLE) & cpu_boundary & ~cpu_hold & ~cpu_reti;
   wire wake_ev  = (cpu_halt & ~cpu_hold & above) |
                   (cpu_hold & (ev_b | ev_d));
   wire [4:0] sts_set = {wake_ev, accept, ev_d, ev_c, ev_b};

   // ----------------------------------------
   // Entry sequence
   // ----------------------------------------
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         S_IDLE:    begin
            if (accept) nxt_state = S_PUSH_LO;
         end
         S_PUSH_LO: nxt_state = S_PUSH_HI;
         S_PUSH_HI: nxt_state = S_LOAD;
         S_LOAD:    nxt_state = S_IDLE;
      endcase
   end

   wire        nxt_ram_we    = (nxt_state == S_PUSH_LO) | (nxt_state == S_PUSH_HI);
   // The first push leaves on the accept edge itself, before the saved copy exists
   wire [15:0] nxt_ram_addr  = (nxt_state == S_PUSH_LO) ? cpu_sp + 16'h0001 :
                               sp_sv_ff + 16'h0002;
   wire [8:0]  nxt_ram_wdata = (nxt_state == S_PUSH_LO) ? {program_bank_flag, cpu_pc[7:0]} :
                               pc_sv_ff;
   wire [16:0] vec_addr      = VEC_BASE + VEC_STEP * {13'h0000, vec_ff};

   // ----------------------------------------
   // Sequential logic
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h00000000;
      end else begin
         ack_ff  <= bus_req & ~ack_ff;
         rdat_ff <= bus_req & ~ack_ff ? rd_val : rdat_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lvlsel_ff <= LVLSEL_RST;
         cfg_ff    <= CFG_RST;
         ena_ff    <= ENABLE_RST;
         sts_ff    <= 5'h00;
         irq_ff    <= 1'b0;
      end else begin
         if (wr_lvlsel) lvlsel_ff <= lvl_wr[9:0];
         if (wr_cfg) cfg_ff <= cfg_wr[5:0];
         if (wr_enable) ena_ff <= ena_wr[4:0];
         // Set beats clear so an event in the clearing cycle survives
         sts_ff <= (sts_ff & ~clr_bits) | sts_set;
         irq_ff <= |sts_live;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         b_prev_ff  <= 1'b0;
         c_prev_ff  <= 1'b0;
         d_prev_ff  <= 1'b0;
         c_flt_ff   <= 1'b0;
         flt_cnt_ff <= 8'h00;
      end else begin
         b_prev_ff  <= ext_irq_b;
         c_prev_ff  <= c_flt_ff;
         d_prev_ff  <= ext_irq_d;
         c_flt_ff   <= nxt_c_flt;
         flt_cnt_ff <= nxt_flt_cnt;
      end
   end

   // Levels only rise while nesting, so three entries never overflow
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_lvl_ff <= LVL_NONE;
         depth_ff   <= 2'h0;
         for (int k = 0; k < STK_DEPTH; k++) lvl_stk_ff[k] <= LVL_NONE;
      end else if (accept) begin
         lvl_stk_ff[depth_ff] <= cur_lvl_ff;
         depth_ff   <= depth_ff + 2'h1;
         cur_lvl_ff <= best_lvl;
      end else if (pop) begin
         depth_ff   <= depth_ff - 2'h1;
         cur_lvl_ff <= lvl_stk_ff[depth_ff - 2'h1];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= S_IDLE;
         vec_ff     <= 4'h0;
         pc_sv_ff   <= 9'h000;
         sp_sv_ff   <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         if (accept) begin
            vec_ff     <= best_idx;
            pc_sv_ff   <= cpu_pc[16:8];
            sp_sv_ff   <= cpu_sp;
         end
      end
   end

   // Reset presents a load of the reset address during and right after reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ram_we_ff    <= 1'b0;
         ram_addr_ff  <= 16'h0000;
         ram_wdata_ff <= 9'h000;
         sp_load_ff   <= 1'b0;
         sp_val_ff    <= 16'h0000;
         pc_load_ff   <= 1'b1;
         pc_val_ff    <= RESET_PC;
         wake_ff      <= 1'b0;
      end else begin
         ram_we_ff    <= nxt_ram_we;
         ram_addr_ff  <= nxt_ram_addr;
         ram_wdata_ff <= nxt_ram_wdata;
         sp_load_ff   <= nxt_state == S_PUSH_HI;
         sp_val_ff    <= sp_sv_ff + 16'h0002;
         pc_load_ff   <= nxt_state == S_LOAD;
         pc_val_ff    <= state_ff == S_PUSH_HI ? vec_addr : pc_val_ff;
         wake_ff      <= wake_ev;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign wb_ack    = ack_ff;
   assign wb_dat_r  = rdat_ff;
   assign ram_we    = ram_we_ff;
   assign ram_addr  = ram_addr_ff;
   assign ram_wdata = ram_wdata_ff;
   assign sp_load   = sp_load_ff;
   assign sp_val    = sp_val_ff;
   assign pc_load   = pc_load_ff;
   assign pc_val    = pc_val_ff;
   assign wake      = wake_ff;
   assign irq       = irq_ff;

endmodule : tlviu_ctrl

/* verilog/tlviu_pkg.sv */
package tlviu_pkg;

   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int NUM_SRC   = 21;
   localparam int NUM_VEC   = 10;
   localparam int NUM_XVEC  = 2;
   localparam int STK_DEPTH = 3;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_LVLSEL = 8'h00;
   localparam logic [7:0] OFS_CFG    = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_CLEAR  = 8'h0C;
   localparam logic [7:0] OFS_ENABLE = 8'h10;
   localparam logic [7:0] OFS_INSVC  = 8'h14;
   localparam logic [7:0] OFS_PEND   = 8'h18;

   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam int CFG_C_EDGE = 0;
   localparam int CFG_D_EDGE = 2;
   localparam int CFG_FLT    = 4;
   localparam logic [9:0] LVLSEL_RST = 10'h000;
   localparam logic [5:0] CFG_RST    = 6'h05;
   localparam logic [4:0] ENABLE_RST = 5'h00;
   localparam int STS_EXT_B  = 0;
   localparam int STS_EXT_C  = 1;
   localparam int STS_EXT_D  = 2;
   localparam int STS_ACCEPT = 3;
   localparam int STS_WAKE   = 4;
   localparam int STS_W      = 5;

   // ----------------------------------------
   // Sources and vectors
   // ----------------------------------------
   localparam int SRC_EXT_B = 4;
   localparam int SRC_EXT_D = 6;
   localparam int SRC_EXT_C = 7;
   localparam logic [20:0] VEC_MASK [0:9] = '{21'h000003, 21'h00000C, 21'h000070, 21'h000180,
                                              21'h000200, 21'h000C00, 21'h001000, 21'h006000,
                                              21'h078000, 21'h180000};
   localparam logic [16:0] RESET_PC = 17'h00000;
   localparam logic [16:0] VEC_BASE = 17'h00003;
   localparam logic [16:0] VEC_STEP = 17'h00008;

   // ----------------------------------------
   // Filter timing
   // ----------------------------------------
   localparam int TCYC_CLKS  = 1;
   localparam int FLT_SHORT  = 1;
   localparam int FLT_MID    = 32;
   localparam int FLT_LONG   = 128;
   localparam logic [7:0] FLT_SHORT_CLKS = 8'(FLT_SHORT * TCYC_CLKS);
   localparam logic [7:0] FLT_MID_CLKS   = 8'(FLT_MID * TCYC_CLKS);
   localparam logic [7:0] FLT_LONG_CLKS  = 8'(FLT_LONG * TCYC_CLKS);

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {LVL_NONE = 2'h0, LVL_L = 2'h1, LVL_H = 2'h2, LVL_X = 2'h3} tlviu_lvl_t;
   typedef enum logic [3:0] {S_IDLE = 4'h1, S_PUSH_LO = 4'h2, S_PUSH_HI = 4'h4, S_LOAD = 4'h8} tlviu_state_t;

endpackage : tlviu_pkg
